// ===== rtl/rtcam_pkg.sv
// constants, field positions and bcd helpers for the rtc register map and alarm comparators
package rtcam_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam int unsigned REG_COUNT = 20;            // 00h..13h live in the register array
  localparam logic [7:0] ADDR_SECONDS = 8'h00;
  localparam logic [7:0] ADDR_MINUTES = 8'h01;
  localparam logic [7:0] ADDR_HOURS = 8'h02;
  localparam logic [7:0] ADDR_DAY_OF_WEEK = 8'h03;
  localparam logic [7:0] ADDR_DAY_OF_MONTH = 8'h04;
  localparam logic [7:0] ADDR_MONTH_AND_CENTURY = 8'h05;
  localparam logic [7:0] ADDR_YEAR = 8'h06;
  localparam logic [7:0] ADDR_FIRST_ALARM_SECONDS = 8'h07;
  localparam logic [7:0] ADDR_FIRST_ALARM_MINUTES = 8'h08;
  localparam logic [7:0] ADDR_FIRST_ALARM_HOURS = 8'h09;
  localparam logic [7:0] ADDR_FIRST_ALARM_DAY_DATE = 8'h0a;
  localparam logic [7:0] ADDR_SECOND_ALARM_MINUTES = 8'h0b;
  localparam logic [7:0] ADDR_SECOND_ALARM_HOURS = 8'h0c;
  localparam logic [7:0] ADDR_SECOND_ALARM_DAY_DATE = 8'h0d;
  localparam logic [7:0] ADDR_CONTROL = 8'h0e;
  localparam logic [7:0] ADDR_STATUS = 8'h0f;
  localparam logic [7:0] ADDR_FREQUENCY_TRIM = 8'h10;
  localparam logic [7:0] ADDR_TEMPERATURE_HIGH_BYTE = 8'h11;
  localparam logic [7:0] ADDR_TEMPERATURE_LOW_BYTE = 8'h12;
  localparam logic [7:0] ADDR_TEST_AND_SOFT_RESET = 8'h13;
  localparam logic [7:0] ADDR_USER_MEMORY = 8'h14;
  localparam logic [7:0] PTR_WRAP_AT = 8'h12;         // last timekeeping location
  localparam logic [7:0] PTR_FIRST = 8'h00;
  localparam int unsigned USER_MEMORY_DEPTH = 236;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned MASK_BIT = 7;              // alarm mask in every alarm register
  localparam int unsigned DYDT_BIT = 6;              // weekday_or_monthday_select
  localparam int unsigned MODE12_BIT = 6;            // hours byte: 12-hour mode
  localparam int unsigned PM_BIT = 5;                // afternoon_indicator
  localparam int unsigned CENTURY_BIT = 7;
  localparam int unsigned CTL_CONV = 5;
  localparam int unsigned CTL_OUTPUT_SELECT_IRQ_NOT_WAVE = 2;             // output_select_irq_not_wave
  localparam int unsigned CTL_SECOND_ALARM_IRQ_ENABLE = 1;
  localparam int unsigned CTL_FIRST_ALARM_IRQ_ENABLE = 0;
  localparam int unsigned ST_OSF = 7;
  localparam int unsigned ST_A2F = 1;
  localparam int unsigned ST_A1F = 0;
  localparam logic [7:0] STATUS_PLAIN_WMASK = 8'h48;  // bits written as given
  localparam logic [7:0] TEST_WMASK = 8'h80;          // soft reset bit only

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] CONTROL_RST = 8'h1c;
  localparam logic [7:0] STATUS_RST = 8'hc8;
  localparam logic [7:0] TIME_ZERO_RST = 8'h00;
  localparam logic [7:0] CAL_ONE_RST = 8'h01;

  // ****************************************************************
  // bcd limits
  // ****************************************************************
  localparam logic [6:0] BCD_59 = 7'h59;
  localparam logic [6:0] BCD_00 = 7'h00;
  localparam logic [5:0] BCD_23 = 6'h23;
  localparam logic [4:0] BCD_11 = 5'h11;
  localparam logic [4:0] BCD_12 = 5'h12;
  localparam logic [4:0] BCD_01 = 5'h01;
  localparam logic [2:0] DOW_LAST = 3'h7;
  localparam logic [2:0] DOW_FIRST = 3'h1;
  localparam logic [7:0] YEAR_LAST = 8'h99;

  // next bcd value, units then tens, no wrap
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc

  // leap year on a two-digit bcd year, valid to 2099
  function automatic logic bcd_leap(input logic [7:0] y);
    if (y[4]) begin
      bcd_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      bcd_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
  endfunction : bcd_leap

  // last date of a bcd month
  function automatic logic [5:0] month_last_date(input logic [4:0] m, input logic leap);
    unique case (m)
      5'h02: month_last_date = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: month_last_date = 6'h30;
      default: month_last_date = 6'h31;
    endcase
  endfunction : month_last_date

endpackage : rtcam_pkg

// ===== rtl/rtcam_alarm_core.sv
// rtc timekeeping register map, calendar advance and the two alarm comparators
// Overview of operation
// - alarm one: seconds..day/date at 07h-0Ah
// - alarm two: minutes..day/date at 0Bh-0Dh
// - bit 7 of alarm bytes masks field
// - no masks: all stored fields must match
// - day/date bit 6 picks weekday or date
// - select 0 date, select 1 weekday
// - match sets that alarm's flag
// - irq needs flag, enable and irq select
// - compare only on once-per-second update
// - alarm one: every second or seconds match
// - alarm one: minutes and seconds match
// - alarm one: hours, minutes, seconds match
// - alarm one: plus date or weekday match
// - alarm two: all masked, once per minute
// - alarm two: minutes match at seconds zero
// - alarm two: hours and minutes match
// - alarm two: plus date or weekday match
// - undefined power-up registers not relied upon
// - time and alarm fields are bcd
// - hours bit 6 12h mode, bit 5 pm/20h
// - pointer wraps from 12h to 00h
// - irq select low gives 1hz square wave
`timescale 1ns/1ps
`default_nettype none

module rtcam_alarm_core #(
  parameter int unsigned USER_MEMORY_DEPTH = rtcam_pkg::USER_MEMORY_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // once-per-second source, asynchronous
  input wire logic one_hz_in,
  // register port behind the serial engine
  input wire logic reg_ptr_load,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // open-drain interrupt / square wave pin
  output logic irq_or_wave_out,
  output logic irq_or_wave_oe
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic tick_s1;                                   // synchroniser, first stage
    logic tick_s2;                                   // synchroniser, second stage
    logic tick_prev;                                 // for edge detection
    logic chk;                                       // compare after the update
    logic [7:0] ptr;                                 // register pointer
    logic [7:0] rdata;                               // read data
    logic oe;                                        // pin pulled low
    logic [rtcam_pkg::REG_COUNT-1:0][7:0] regs;      // 00h..13h
    logic [USER_MEMORY_DEPTH-1:0][7:0] mem;          // 14h..FFh
  } rtcam_state_t;

  rtcam_state_t s_q;
  rtcam_state_t s_d;
  logic rst_s1_q;                                    // reset release synchroniser
  logic rst_s2_q;
  logic tick;                                        // once-per-second update
  logic a1_match;
  logic a2_match;
  logic day_roll;                                    // hours rolled past midnight
  logic [7:0] rd_val;

  // ****************************************************************
  // reset release
  // ****************************************************************
  // assert at once, release two edges later so no flop leaves reset on a partial edge
  // the released copy also gates every assertion below
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // ****************************************************************
  // field views
  // ****************************************************************
  // current time fields, bcd throughout
  wire logic [7:0] sec_r = s_q.regs[rtcam_pkg::ADDR_SECONDS];
  wire logic [7:0] min_r = s_q.regs[rtcam_pkg::ADDR_MINUTES];
  wire logic [7:0] hr_r = s_q.regs[rtcam_pkg::ADDR_HOURS];
  wire logic [7:0] dow_r = s_q.regs[rtcam_pkg::ADDR_DAY_OF_WEEK];
  wire logic [7:0] date_r = s_q.regs[rtcam_pkg::ADDR_DAY_OF_MONTH];
  wire logic [7:0] mon_r = s_q.regs[rtcam_pkg::ADDR_MONTH_AND_CENTURY];
  wire logic [7:0] yr_r = s_q.regs[rtcam_pkg::ADDR_YEAR];
  // alarm one bytes, 07h..0Ah
  wire logic [7:0] a1s_r = s_q.regs[rtcam_pkg::ADDR_FIRST_ALARM_SECONDS];
  wire logic [7:0] a1m_r = s_q.regs[rtcam_pkg::ADDR_FIRST_ALARM_MINUTES];
  wire logic [7:0] a1h_r = s_q.regs[rtcam_pkg::ADDR_FIRST_ALARM_HOURS];
  wire logic [7:0] a1d_r = s_q.regs[rtcam_pkg::ADDR_FIRST_ALARM_DAY_DATE];
  // alarm two bytes, 0Bh..0Dh, no seconds byte
  wire logic [7:0] a2m_r = s_q.regs[rtcam_pkg::ADDR_SECOND_ALARM_MINUTES];
  wire logic [7:0] a2h_r = s_q.regs[rtcam_pkg::ADDR_SECOND_ALARM_HOURS];
  wire logic [7:0] a2d_r = s_q.regs[rtcam_pkg::ADDR_SECOND_ALARM_DAY_DATE];
  // control and status views feed the flag and pin logic
  wire logic [7:0] ctl_r = s_q.regs[rtcam_pkg::ADDR_CONTROL];
  wire logic [7:0] st_r = s_q.regs[rtcam_pkg::ADDR_STATUS];

  // mask bits, bit 7 of each alarm byte
  wire logic first_alarm_seconds_mask = a1s_r[rtcam_pkg::MASK_BIT];
  wire logic first_alarm_minutes_mask = a1m_r[rtcam_pkg::MASK_BIT];
  wire logic first_alarm_hours_mask = a1h_r[rtcam_pkg::MASK_BIT];
  wire logic first_alarm_daydate_mask = a1d_r[rtcam_pkg::MASK_BIT];
  wire logic second_alarm_minutes_mask = a2m_r[rtcam_pkg::MASK_BIT];
  wire logic second_alarm_hours_mask = a2h_r[rtcam_pkg::MASK_BIT];
  wire logic second_alarm_daydate_mask = a2d_r[rtcam_pkg::MASK_BIT];
  wire logic first_alarm_flag = st_r[rtcam_pkg::ST_A1F];
  wire logic second_alarm_flag = st_r[rtcam_pkg::ST_A2F];
  wire logic first_alarm_irq_enable = ctl_r[rtcam_pkg::CTL_FIRST_ALARM_IRQ_ENABLE];
  wire logic second_alarm_irq_enable = ctl_r[rtcam_pkg::CTL_SECOND_ALARM_IRQ_ENABLE];
  wire logic output_select_irq_not_wave = ctl_r[rtcam_pkg::CTL_OUTPUT_SELECT_IRQ_NOT_WAVE];

  // ****************************************************************
  // comparators
  // ****************************************************************
  // day/date byte: bit 6 chooses weekday (1) or date of month (0) for bits 5..0
  function automatic logic daydate_eq(input logic [7:0] a, input logic [7:0] dow, input logic [7:0] date);
    if (a[rtcam_pkg::DYDT_BIT]) begin
      daydate_eq = (a[5:0] == {3'h0, dow[2:0]});
    end else begin
      daydate_eq = (a[5:0] == date[5:0]);
    end
  endfunction : daydate_eq

  // a set mask drops its field; hours compared with mode and pm bits included
  // so an alarm written in the other hour mode never matches
  // unlisted mask mixes fall out as the plain per-field and of the terms
  assign a1_match = (first_alarm_seconds_mask | (a1s_r[6:0] == sec_r[6:0]))
                  & (first_alarm_minutes_mask | (a1m_r[6:0] == min_r[6:0]))
                  & (first_alarm_hours_mask | (a1h_r[6:0] == hr_r[6:0]))
                  & (first_alarm_daydate_mask | daydate_eq(a1d_r, dow_r, date_r));
  // alarm two has no seconds byte and fires only on seconds zero
  assign a2_match = (sec_r[6:0] == rtcam_pkg::BCD_00)
                  & (second_alarm_minutes_mask | (a2m_r[6:0] == min_r[6:0]))
                  & (second_alarm_hours_mask | (a2h_r[6:0] == hr_r[6:0]))
                  & (second_alarm_daydate_mask | daydate_eq(a2d_r, dow_r, date_r));

  // ****************************************************************
  // read mux
  // ****************************************************************
  // combinational pick of the addressed byte; only the registered copy leaves
  // user memory sits above the register array, so its index is offset
  always_comb begin
    if (s_q.ptr < rtcam_pkg::ADDR_USER_MEMORY) begin
      rd_val = s_q.regs[s_q.ptr[4:0]];
    end else begin
      rd_val = s_q.mem[s_q.ptr - rtcam_pkg::ADDR_USER_MEMORY];
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  // order inside: time advance, host write, alarm flag set, so a write beats the
  // advance of the same byte and an alarm set beats a same-cycle flag clear
  always_comb begin
    logic [7:0] hr_n;
    logic [7:0] wr_idx;
    hr_n = hr_r;
    wr_idx = s_q.ptr;
    day_roll = 1'b0;
    s_d = s_q;
    // one_hz_in edge, sampled through two flops first
    // only the second stage reads the first, so no logic sees a metastable level
    s_d.tick_s1 = one_hz_in;
    s_d.tick_s2 = s_q.tick_s1;
    s_d.tick_prev = s_q.tick_s2;
    tick = s_q.tick_s2 & ~s_q.tick_prev;
    s_d.chk = tick;
    // no sensor here: a conversion request completes at once
    s_d.regs[rtcam_pkg::ADDR_CONTROL][rtcam_pkg::CTL_CONV] = 1'b0;

    // calendar advance on the update tick
    if (tick) begin
      s_d.regs[rtcam_pkg::ADDR_SECONDS] = rtcam_pkg::bcd_inc(sec_r);
      if (sec_r[6:0] == rtcam_pkg::BCD_59) begin
        s_d.regs[rtcam_pkg::ADDR_SECONDS] = rtcam_pkg::TIME_ZERO_RST;
        s_d.regs[rtcam_pkg::ADDR_MINUTES] = rtcam_pkg::bcd_inc(min_r);
        if (min_r[6:0] == rtcam_pkg::BCD_59) begin
          s_d.regs[rtcam_pkg::ADDR_MINUTES] = rtcam_pkg::TIME_ZERO_RST;
          if (hr_r[rtcam_pkg::MODE12_BIT]) begin
            // 12-hour: 11 -> 12 flips pm, 12 -> 01
            hr_n = rtcam_pkg::bcd_inc({3'h0, hr_r[4:0]}) | {hr_r[7:5], 5'h00};
            if (hr_r[4:0] == rtcam_pkg::BCD_11) begin
              hr_n = {hr_r[7:6], ~hr_r[rtcam_pkg::PM_BIT], rtcam_pkg::BCD_12};
              day_roll = hr_r[rtcam_pkg::PM_BIT];
            end else if (hr_r[4:0] == rtcam_pkg::BCD_12) begin
              hr_n = {hr_r[7:5], rtcam_pkg::BCD_01};
            end
          end else begin
            // 24-hour: bit 5 is the twenty digit
            hr_n = rtcam_pkg::bcd_inc({2'h0, hr_r[5:0]}) | {hr_r[7:6], 6'h00};
            if (hr_r[5:0] == rtcam_pkg::BCD_23) begin
              hr_n = {hr_r[7:6], 6'h00};
              day_roll = 1'b1;
            end
          end
          s_d.regs[rtcam_pkg::ADDR_HOURS] = hr_n;
        end
      end
      if (day_roll) begin
        s_d.regs[rtcam_pkg::ADDR_DAY_OF_WEEK] = (dow_r[2:0] == rtcam_pkg::DOW_LAST)
          ? {5'h00, rtcam_pkg::DOW_FIRST} : rtcam_pkg::bcd_inc(dow_r);
        s_d.regs[rtcam_pkg::ADDR_DAY_OF_MONTH] = rtcam_pkg::bcd_inc(date_r);
        if (date_r[5:0] == rtcam_pkg::month_last_date(mon_r[4:0], rtcam_pkg::bcd_leap(yr_r))) begin
          s_d.regs[rtcam_pkg::ADDR_DAY_OF_MONTH] = rtcam_pkg::CAL_ONE_RST;
          s_d.regs[rtcam_pkg::ADDR_MONTH_AND_CENTURY] = rtcam_pkg::bcd_inc(mon_r);
          if (mon_r[4:0] == rtcam_pkg::BCD_12) begin
            s_d.regs[rtcam_pkg::ADDR_MONTH_AND_CENTURY] =
              {mon_r[rtcam_pkg::CENTURY_BIT], 7'h01};
            s_d.regs[rtcam_pkg::ADDR_YEAR] = rtcam_pkg::bcd_inc(yr_r);
            if (yr_r == rtcam_pkg::YEAR_LAST) begin
              // year rolls 99 -> 00 and the century bit toggles
              s_d.regs[rtcam_pkg::ADDR_YEAR] = rtcam_pkg::TIME_ZERO_RST;
              s_d.regs[rtcam_pkg::ADDR_MONTH_AND_CENTURY][rtcam_pkg::CENTURY_BIT] =
                ~mon_r[rtcam_pkg::CENTURY_BIT];
            end
          end
        end
      end
    end

    // pointer: load, or step after each access, wrapping at the top of timekeeping
    // a pointer loaded above the wrap point steps on and rolls over at ffh
    if (reg_ptr_load) begin
      s_d.ptr = reg_addr;
    end else if (reg_wr | reg_rd) begin
      s_d.ptr = (s_q.ptr == rtcam_pkg::PTR_WRAP_AT) ? rtcam_pkg::PTR_FIRST : s_q.ptr + 8'h01;
    end

    // read: data registered, one cycle after the strobe
    if (!reg_ptr_load && reg_rd) begin
      s_d.rdata = rd_val;
    end

    // write at the pointer
    // read-only and partly writable bytes are filtered in the case below
    if (!reg_ptr_load && reg_wr) begin
      if (wr_idx >= rtcam_pkg::ADDR_USER_MEMORY) begin
        s_d.mem[wr_idx - rtcam_pkg::ADDR_USER_MEMORY] = reg_wdata;
      end else begin
        unique case (wr_idx)
          rtcam_pkg::ADDR_STATUS: begin
            // osf and alarm flags: a written zero clears, a one leaves them
            s_d.regs[rtcam_pkg::ADDR_STATUS] =
              (st_r & reg_wdata & ~rtcam_pkg::STATUS_PLAIN_WMASK)
              | (reg_wdata & rtcam_pkg::STATUS_PLAIN_WMASK);
          end
          rtcam_pkg::ADDR_TEMPERATURE_HIGH_BYTE, rtcam_pkg::ADDR_TEMPERATURE_LOW_BYTE: begin
            // read only, write ignored
          end
          rtcam_pkg::ADDR_TEST_AND_SOFT_RESET: begin
            s_d.regs[rtcam_pkg::ADDR_TEST_AND_SOFT_RESET] = reg_wdata & rtcam_pkg::TEST_WMASK;
          end
          default: begin
            s_d.regs[wr_idx[4:0]] = reg_wdata;
          end
        endcase
      end
    end

    // alarm flags: set on the compare cycle only, and the set wins over a clear
    // the compare looks at the time already advanced by the tick one cycle back
    if (s_q.chk && a1_match) begin
      s_d.regs[rtcam_pkg::ADDR_STATUS][rtcam_pkg::ST_A1F] = 1'b1;
    end
    if (s_q.chk && a2_match) begin
      s_d.regs[rtcam_pkg::ADDR_STATUS][rtcam_pkg::ST_A2F] = 1'b1;
    end

    // pin: alarm interrupt when selected, otherwise the 1 hz wave (low half pulls)
    // oe is registered so a decode hazard never reaches the pin
    if (output_select_irq_not_wave) begin
      s_d.oe = (first_alarm_flag & first_alarm_irq_enable)
             | (second_alarm_flag & second_alarm_irq_enable);
    end else begin
      s_d.oe = ~s_q.tick_s2;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // alarm and trim bytes have no defined power-up value; cleared here but
  // software is expected to program them before use
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      s_q <= '0;
      s_q.regs[rtcam_pkg::ADDR_DAY_OF_WEEK] <= rtcam_pkg::CAL_ONE_RST;
      s_q.regs[rtcam_pkg::ADDR_DAY_OF_MONTH] <= rtcam_pkg::CAL_ONE_RST;
      s_q.regs[rtcam_pkg::ADDR_MONTH_AND_CENTURY] <= rtcam_pkg::CAL_ONE_RST;
      s_q.regs[rtcam_pkg::ADDR_CONTROL] <= rtcam_pkg::CONTROL_RST;
      s_q.regs[rtcam_pkg::ADDR_STATUS] <= rtcam_pkg::STATUS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; the pin is only ever pulled low
  assign reg_rdata = s_q.rdata;
  assign irq_or_wave_out = 1'b0;
  assign irq_or_wave_oe = s_q.oe;

  // ****************************************************************
  // assertions
  // ****************************************************************
  // all checks share the system clock and sleep while the internal reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s2_q);

  a_alarm1_sets: assert property (s_q.chk && a1_match |=> first_alarm_flag)
    else $error("alarm one match did not set its flag");
  a_alarm2_sets: assert property (s_q.chk && a2_match |=> second_alarm_flag)
    else $error("alarm two match did not set its flag");
  a_only_on_tick: assert property (!s_q.chk && !first_alarm_flag && !(reg_wr && !reg_ptr_load
      && s_q.ptr == rtcam_pkg::ADDR_STATUS) |=> !first_alarm_flag)
    else $error("alarm one flag set outside the update");
  a_every_second: assert property (s_q.chk && first_alarm_seconds_mask && first_alarm_minutes_mask
      && first_alarm_hours_mask && first_alarm_daydate_mask |=> first_alarm_flag)
    else $error("fully masked alarm one did not fire");
  a_hours_differ: assert property (s_q.chk && !first_alarm_flag && !first_alarm_hours_mask
      && (a1h_r[6:0] != hr_r[6:0]) && !reg_wr |=> !first_alarm_flag)
    else $error("alarm one fired with hours unequal");
  a_a2_sec_zero: assert property ($rose(second_alarm_flag) |-> $past(sec_r[6:0]) == rtcam_pkg::BCD_00)
    else $error("alarm two fired off seconds zero");
  a_flag_holds: assert property (first_alarm_flag && !(reg_wr && !reg_ptr_load
      && s_q.ptr == rtcam_pkg::ADDR_STATUS) |=> first_alarm_flag)
    else $error("alarm one flag dropped without a write");
  a_irq_gate: assert property (output_select_irq_not_wave |=> irq_or_wave_oe ==
      $past((first_alarm_flag & first_alarm_irq_enable) | (second_alarm_flag & second_alarm_irq_enable)))
    else $error("interrupt pin disagrees with flags and enables");
  a_wave_mode: assert property (!output_select_irq_not_wave |=> irq_or_wave_oe == !$past(s_q.tick_s2))
    else $error("square wave not on the pin");
  a_ptr_wrap: assert property ((reg_wr || reg_rd) && !reg_ptr_load && s_q.ptr == rtcam_pkg::PTR_WRAP_AT
      |=> s_q.ptr == rtcam_pkg::PTR_FIRST)
    else $error("pointer did not wrap to zero");
  a_a2_on_tick: assert property (!s_q.chk && !second_alarm_flag && !(reg_wr && !reg_ptr_load
      && s_q.ptr == rtcam_pkg::ADDR_STATUS) |=> !second_alarm_flag)
    else $error("alarm two flag set outside the update");
  a_all_fields_needed: assert property (s_q.chk && !first_alarm_flag && !first_alarm_seconds_mask
      && !first_alarm_minutes_mask && !first_alarm_hours_mask && !first_alarm_daydate_mask
      && (a1s_r[6:0] != sec_r[6:0]) && !reg_wr |=> !first_alarm_flag)
    else $error("unmasked alarm one fired with seconds unequal");
  a_minute_repeat: assert property (s_q.chk && second_alarm_minutes_mask && second_alarm_hours_mask
      && second_alarm_daydate_mask && (sec_r[6:0] == rtcam_pkg::BCD_00) |=> second_alarm_flag)
    else $error("fully masked alarm two missed seconds zero");

  // ****************************************************************
  // cover points
  // ****************************************************************
  // both alarms firing, the pin in each mode and a pointer wrap
  c_alarm1: cover property ($rose(first_alarm_flag));
  c_alarm2: cover property ($rose(second_alarm_flag));
  c_irq: cover property (output_select_irq_not_wave && $rose(irq_or_wave_oe));
  c_wrap: cover property (reg_rd && s_q.ptr == rtcam_pkg::PTR_WRAP_AT ##1 reg_rd);
  c_wave: cover property (!output_select_irq_not_wave && $fell(irq_or_wave_oe));

endmodule : rtcam_alarm_core

`default_nettype wire

// ===== testbench/rtcam_host.sv
// host model: drives the register port in place of the serial master
`timescale 1ns/1ps
`default_nettype none
module rtcam_host (
  // clock
  input wire logic clk,
  // register port
  output logic reg_ptr_load,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // idle strobes from time zero
  initial begin
    {reg_ptr_load, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  end
  // one access a cycle; every strobe set once per falling edge, never released mid-step
  task automatic put(input logic l, input logic w, input logic r, input logic [7:0] d);
    @(negedge clk);
    {reg_ptr_load, reg_wr, reg_rd} = {l, w, r};
    reg_addr = d;
    reg_wdata = d;
  endtask : put
  // read strobe, then one idle cycle so the registered data has landed
  task automatic rd(output logic [7:0] v);
    put(1'b0, 1'b0, 1'b1, 8'h00);
    put(1'b0, 1'b0, 1'b0, 8'h00);
    v = reg_rdata;
  endtask : rd
endmodule : rtcam_host
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the rtc register map and alarm comparators
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************************************
  // wiring
  // ****************************************************************
  logic clk, resetn, one_hz_in, reg_ptr_load, reg_wr, reg_rd, oe, out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  int err_count = 0;
  int n_compared = 0;
  // rows: alarm bytes 07h..0dh, control, expected {a2 flag, a1 flag}; time after tick is 00:05:00
  localparam logic [71:0] ROWS [7] = '{72'h80808080_808080_07_03, 72'h00808080_058080_07_03,
    72'h01808080_068080_07_00, 72'h00050080_050180_06_01, 72'h00050001_050041_04_03,
    72'h00050042_050002_07_00, 72'h00058080_050080_05_03};
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  rtcam_alarm_core i_rtcam_alarm_core (.clk(clk), .resetn(resetn), .one_hz_in(one_hz_in),
    .reg_ptr_load(reg_ptr_load), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_or_wave_out(out), .irq_or_wave_oe(oe));
  rtcam_host i_rtcam_host (.clk(clk), .reg_ptr_load(reg_ptr_load), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] d);
    i_rtcam_host.put(1'b0, 1'b1, 1'b0, d);
  endtask : wr
  task automatic ld(input logic [7:0] a);
    i_rtcam_host.put(1'b1, 1'b0, 1'b0, a);
  endtask : ld
  // one 80 ns link period, driven on falling clk edges; the line rests low between ticks
  task automatic tick();
    @(negedge clk);
    one_hz_in = 1'b1;
    repeat (5) @(negedge clk);
    one_hz_in = 1'b0;
    repeat (4) @(negedge clk);
  endtask : tick
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // every listed mask combination, both day/date selects and the enables, with pin select held high
  task automatic alarm_table();
    logic [71:0] r;
    for (int i = 0; i < 7; i++) begin
      r = ROWS[i];
      ld(8'h00);
      wr(8'h59);
      wr(8'h04);
      ld(8'h07);
      for (int k = 0; k < 9; k++) wr(k == 8 ? 8'h00 : r[71 - 8 * k -: 8]);
      ld(8'h0f);
      i_rtcam_host.rd(v);
      chk(v, 8'h00);
      tick();
      ld(8'h0f);
      i_rtcam_host.rd(v);
      chk(v, r[7:0]);
      chk({7'h0, oe}, {7'h0, r[10] & |(r[9:8] & r[1:0])});
    end
  endtask : alarm_table
  // flags stay set with no tick, then clear on a zero write and release the pin
  task automatic flag_clear();
    repeat (20) @(negedge clk);
    ld(8'h0f);
    i_rtcam_host.rd(v);
    chk(v, 8'h03);
    ld(8'h0f);
    wr(8'h00);
    ld(8'h0f);
    i_rtcam_host.rd(v);
    chk(v, 8'h00);
    chk({7'h0, oe}, 8'h00);
  endtask : flag_clear
  // pointer steps 12h -> 00h -> 01h; minutes tell it apart from 13h/14h
  task automatic pointer_wrap();
    ld(8'h12);
    i_rtcam_host.rd(v);
    i_rtcam_host.rd(v);
    i_rtcam_host.rd(v);
    chk(v, 8'h05);
  endtask : pointer_wrap
  // pin select low: pin pulled low while the 1 Hz line is low
  task automatic wave_mode();
    ld(8'h0e);
    wr(8'h00);
    i_rtcam_host.put(1'b0, 1'b0, 1'b0, 8'h00);
    repeat (8) @(negedge clk);
    chk({7'h0, oe}, 8'h01);
    chk({7'h0, out}, 8'h00);
    one_hz_in = 1'b1;
    repeat (8) @(negedge clk);
    chk({7'h0, oe}, 8'h00);
    one_hz_in = 1'b0;
    // time is now 00:05:01: alarm two matches minutes and hours but not seconds zero
    ld(8'h0f);
    i_rtcam_host.rd(v);
    chk(v, 8'h00);
  endtask : wave_mode
  // verdict and end of run, shared with the watchdog
  task automatic stop_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    resetn = 1'b0;
    one_hz_in = 1'b0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    alarm_table();
    flag_clear();
    pointer_wrap();
    wave_mode();
    stop_test();
  end
  // watchdog: the run needs a few microseconds
  initial begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
